// ==== verilog/cdr_lock_ctrl.v ====
// Lock controller, deserializer hookup, interrupts and AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "cdr_consts.vh"

module cdr_lock_ctrl #(
	parameter REC_DIV = `CDR_REC_DIV
) (
	input wire ref_clk_in,
	input wire reset_n_in,
	// Detector and link pins
	input wire ppm_in_range_in,
	input wire phase_ok_in,
	input wire signal_detect_in,
	input wire force_lock_ref_in,
	input wire force_lock_data_in,
	input wire rx_bit_rise_in,
	input wire rx_bit_fall_in,
	// Fabric side
	output wire freq_locked_out,
	output wire lock_state_out,
	output wire [`CDR_WORD_MAX-1:0] rx_word_out,
	output wire rx_word_valid_out,
	output wire irq_out,
	// AXI4-Lite slave
	input wire [`CDR_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`CDR_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// Byte-lane merge for write strobes
	function [31:0] cdr_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			cdr_merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					cdr_merge[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	function cdr_known;
		input [`CDR_ADDR_W-1:0] addr;
		begin
			cdr_known = (addr == `CDR_OFS_CTRL) ||
				(addr == `CDR_OFS_STATUS) ||
				(addr == `CDR_OFS_INT_STAT) ||
				(addr == `CDR_OFS_INT_MASK) ||
				(addr == `CDR_OFS_RX_WORD);
		end
	endfunction

	// Two-stage synchronisers for pin inputs
	reg [6:0] sync1_q;
	reg [6:0] sync2_q;
	wire ppm_ok;
	wire phase_ok;
	wire sig_ok;
	wire force_ref;
	wire force_data;
	wire bit_rise;
	wire bit_fall;

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {rx_bit_fall_in, rx_bit_rise_in,
				force_lock_data_in, force_lock_ref_in,
				signal_detect_in, phase_ok_in, ppm_in_range_in};
			sync2_q <= sync1_q;
		end
	end

	assign ppm_ok = sync2_q[0];
	assign phase_ok = sync2_q[1];
	assign sig_ok = sync2_q[2];
	assign force_ref = sync2_q[3];
	assign force_data = sync2_q[4];
	assign bit_rise = sync2_q[5];
	assign bit_fall = sync2_q[6];

	// Control and interrupt registers
	reg [`CDR_CTRL_W-1:0] ctrl_q;
	reg [`CDR_INT_W-1:0] int_stat_q;
	reg [`CDR_INT_W-1:0] int_mask_q;
	wire manual_en;
	wire pipe_mode;
	wire width10;

	assign manual_en = ctrl_q[`CDR_CTRL_MANUAL];
	assign pipe_mode = ctrl_q[`CDR_CTRL_PIPE];
	assign width10 = ctrl_q[`CDR_CTRL_WIDTH10];

	// Lock state machine
	reg state_q;
	reg state_d;
	reg auto_d;

	always @* begin
		auto_d = state_q;
		case (state_q)
			`CDR_ST_REF: begin
				if (ppm_ok && phase_ok) begin // R4
					auto_d = `CDR_ST_DATA;
				end
			end
			`CDR_ST_DATA: begin
				if (!ppm_ok) begin // R2
					auto_d = `CDR_ST_REF;
				end else if (pipe_mode && !sig_ok) begin // R1
					auto_d = `CDR_ST_REF;
				end
			end
			default: begin
				auto_d = `CDR_ST_REF;
			end
		endcase
	end

	// Manual overrides sit on top of the automatic choice
	always @* begin
		state_d = auto_d; // R7
		if (manual_en) begin // R5
			if (force_data) begin // R12
				state_d = `CDR_ST_DATA;
			end else if (force_ref) begin // R12
				state_d = `CDR_ST_REF;
			end
		end
	end

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= `CDR_ST_REF; // R11
		end else begin
			state_q <= state_d;
		end
	end

	// Flag follows the state in both modes
	assign freq_locked_out = (state_q == `CDR_ST_DATA); // R3 R6
	assign lock_state_out = state_q;

	// State edges feed the sticky status
	wire lock_gain;
	wire lock_loss;

	assign lock_gain = (state_q == `CDR_ST_REF) &&
		(state_d == `CDR_ST_DATA);
	assign lock_loss = (state_q == `CDR_ST_DATA) &&
		(state_d == `CDR_ST_REF);

	// Recovered-clock rate step enable
	reg [7:0] div_q;
	wire step;

	assign step = (div_q == 8'h00);

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= 8'h00;
		end else if (step) begin
			div_q <= REC_DIV[7:0] - 8'h01;
		end else begin
			div_q <= div_q - 8'h01;
		end
	end

	// Deserializer runs only while tracking data
	wire [`CDR_WORD_MAX-1:0] word;
	wire word_valid;

	cdr_deser #(
		.WORD_MAX(`CDR_WORD_MAX)
	) u_deser (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.step_in(step),
		.bit_rise_in(bit_rise),
		.bit_fall_in(bit_fall),
		.width10_in(width10),
		.clear_in(state_q == `CDR_ST_REF),
		.word_out(word),
		.word_valid_out(word_valid)
	);

	assign rx_word_out = word;
	assign rx_word_valid_out = word_valid;

	// AXI4-Lite write path
	reg aw_got_q;
	reg w_got_q;
	reg [`CDR_ADDR_W-1:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire wr_fire;
	wire [31:0] ctrl_wr;
	wire [31:0] mask_wr;
	wire [31:0] clr_wr;
	reg [`CDR_INT_W-1:0] int_clr;
	reg [`CDR_INT_W-1:0] int_set;

	// Each half held until the response handshake
	assign s_axi_awready = !aw_got_q;
	assign s_axi_wready = !w_got_q;
	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
	assign ctrl_wr = cdr_merge({29'h0, ctrl_q}, wdata_q, wstrb_q);
	assign mask_wr = cdr_merge({29'h0, int_mask_q}, wdata_q, wstrb_q);
	assign clr_wr = cdr_merge(32'h0, wdata_q, wstrb_q);

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= {`CDR_ADDR_W{1'b0}};
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CDR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_got_q) begin
				aw_got_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got_q) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= cdr_known(waddr_q) ?
					`CDR_RESP_OKAY : `CDR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_q <= `CDR_CTRL_RESET;
			int_mask_q <= {`CDR_INT_W{1'b0}};
		end else if (wr_fire) begin
			if (waddr_q == `CDR_OFS_CTRL) begin
				ctrl_q <= ctrl_wr[`CDR_CTRL_W-1:0];
			end
			if (waddr_q == `CDR_OFS_INT_MASK) begin
				int_mask_q <= mask_wr[`CDR_INT_W-1:0];
			end
		end
	end

	// Sticky status; a new event wins over a clear
	always @* begin
		int_clr = {`CDR_INT_W{1'b0}};
		if (wr_fire && waddr_q == `CDR_OFS_INT_STAT) begin
			int_clr = clr_wr[`CDR_INT_W-1:0];
		end
		int_set = {`CDR_INT_W{1'b0}};
		int_set[`CDR_INT_LOCKED] = lock_gain;
		int_set[`CDR_INT_UNLOCKED] = lock_loss;
		int_set[`CDR_INT_WORD] = word_valid;
	end

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			int_stat_q <= {`CDR_INT_W{1'b0}};
		end else begin
			int_stat_q <= (int_stat_q & ~int_clr) | int_set;
		end
	end

	assign irq_out = |(int_stat_q & int_mask_q);

	// AXI4-Lite read path
	reg [31:0] rd_val;

	// One read in flight; unmapped reads give zero
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		rd_val = 32'h0;
		case (s_axi_araddr)
			`CDR_OFS_CTRL: begin
				rd_val[`CDR_CTRL_W-1:0] = ctrl_q;
			end
			`CDR_OFS_STATUS: begin
				rd_val[3:0] = {sig_ok, phase_ok, ppm_ok, state_q};
			end
			`CDR_OFS_INT_STAT: begin
				rd_val[`CDR_INT_W-1:0] = int_stat_q;
			end
			`CDR_OFS_INT_MASK: begin
				rd_val[`CDR_INT_W-1:0] = int_mask_q;
			end
			`CDR_OFS_RX_WORD: begin
				rd_val[`CDR_WORD_MAX-1:0] = word;
			end
			default: begin
				rd_val = 32'h0;
			end
		endcase
	end

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `CDR_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= cdr_known(s_axi_araddr) ?
				`CDR_RESP_OKAY : `CDR_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // cdr_lock_ctrl

// ==== verilog/cdr_consts.vh ====
// Constants for the clock-recovery lock controller and deserializer
// Behaviour
// (R1) In data tracking, lost signal detection sends the loop back to reference tracking only in PCIe PIPE mode.
// (R2) In data tracking, a recovered clock outside the ppm threshold sends the loop back to reference tracking.
// (R3) In automatic mode the locked flag rises on the move to data tracking and falls on the move back.
// (R4) In automatic mode the ppm detector and phase detector decide between the two states.
// (R5) In manual mode outside logic drives the two force inputs and the state follows their levels alone.
//      The code applies the automatic decision when neither force input is high.
// (R6) In manual mode the locked flag is high in data tracking and low in reference tracking.
// (R7) Without the manual inputs enabled the controller runs in automatic mode.
// (R8) The deserializer builds parallel words of 8 or 10 bits.
// (R9) The first received bit of a word lands in bit 0 and later bits in rising positions.
// (R10) The deserializer takes two bits per recovered clock period, one on each edge.
// (R11) After reset the controller is in reference tracking with the locked flag low.
// (R12) Force to data wins, else force to reference, else the automatic decision applies.
`ifndef CDR_CONSTS_VH
`define CDR_CONSTS_VH

`define CDR_ADDR_W 8
`define CDR_OFS_CTRL 8'h00
`define CDR_OFS_STATUS 8'h04
`define CDR_OFS_INT_STAT 8'h08
`define CDR_OFS_INT_MASK 8'h0c
`define CDR_OFS_RX_WORD 8'h10

`define CDR_CTRL_MANUAL 0
`define CDR_CTRL_PIPE 1
`define CDR_CTRL_WIDTH10 2
`define CDR_CTRL_W 3
`define CDR_CTRL_RESET 3'h0

`define CDR_INT_LOCKED 0
`define CDR_INT_UNLOCKED 1
`define CDR_INT_WORD 2
`define CDR_INT_W 3

`define CDR_ST_REF 1'b0
`define CDR_ST_DATA 1'b1

`define CDR_RESP_OKAY 2'h0
`define CDR_RESP_SLVERR 2'h2

`define CDR_WORD_MAX 10
`define CDR_REC_DIV 2

`endif

// ==== verilog/cdr_deser.v ====
// Deserializer: two bits per recovered-clock step into 8- or 10-bit words
`timescale 1ns/100ps
`include "cdr_consts.vh"

module cdr_deser #(
	parameter WORD_MAX = `CDR_WORD_MAX
) (
	input wire ref_clk_in,
	input wire reset_n_in,
	input wire step_in,
	input wire bit_rise_in,
	input wire bit_fall_in,
	input wire width10_in,
	input wire clear_in,
	output reg [WORD_MAX-1:0] word_out,
	output reg word_valid_out
);

	reg [WORD_MAX-1:0] acc_q;
	reg [3:0] pos_q;
	wire [3:0] last_pos;
	reg [WORD_MAX-1:0] acc_d;

	assign last_pos = width10_in ? 4'h8 : 4'h6;

	always @* begin
		acc_d = acc_q;
		acc_d[pos_q] = bit_rise_in; // R9
		acc_d[pos_q + 4'h1] = bit_fall_in; // R10
	end

	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc_q <= {WORD_MAX{1'b0}};
			pos_q <= 4'h0;
			word_out <= {WORD_MAX{1'b0}};
			word_valid_out <= 1'b0;
		end else begin
			word_valid_out <= 1'b0;
			if (clear_in) begin
				pos_q <= 4'h0;
				acc_q <= {WORD_MAX{1'b0}};
			end else if (step_in) begin
				if (pos_q == last_pos) begin // R8
					pos_q <= 4'h0;
					acc_q <= {WORD_MAX{1'b0}};
					word_out <= width10_in ? acc_d :
						{2'h0, acc_d[7:0]};
					word_valid_out <= 1'b1;
				end else begin
					pos_q <= pos_q + 4'h2;
					acc_q <= acc_d;
				end
			end
		end
	end

endmodule // cdr_deser

// ==== testbench/cdr_tx_model.sv ====
// Upstream transmitter model: repeats one word LSB first, a pair per step
`timescale 1ns/100ps
module cdr_tx_model (
	input wire ref_clk_in,
	input wire reset_n_in,
	input wire [9:0] word_in,
	input wire wide_in,
	output reg bit_rise_out,
	output reg bit_fall_out
);
	reg [2:0] pair_q;
	reg half_q;
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pair_q <= 3'h0;
			half_q <= 1'b0;
			bit_rise_out <= 1'b0;
			bit_fall_out <= 1'b0;
		end else begin
			half_q <= ~half_q;
			if (half_q) begin
				bit_rise_out <= word_in[2*pair_q];
				bit_fall_out <= word_in[2*pair_q+1];
				if (pair_q == (wide_in ? 3'h4 : 3'h3))
					pair_q <= 3'h0;
				else
					pair_q <= pair_q + 3'h1;
			end
		end
	end
endmodule // cdr_tx_model

// ==== testbench/cdr_lock_ctrl_checker.sv ====
// Assertions on the lock controller ports
`timescale 1ns/100ps
module cdr_lock_ctrl_checker #(
	parameter REC_DIV = 2
) (
	input wire ref_clk_in,
	input wire reset_n_in,
	input wire ppm_in_range_in,
	input wire phase_ok_in,
	input wire signal_detect_in,
	input wire force_lock_ref_in,
	input wire force_lock_data_in,
	input wire freq_locked_out,
	input wire lock_state_out,
	input wire rx_word_valid_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_reset_ref;
		!$past(reset_n_in) |-> !lock_state_out;
	endproperty
	a_reset_ref: assert property (p_reset_ref)
		else $error("Not in reference tracking after reset");
	property p_flag;
		freq_locked_out == lock_state_out;
	endproperty
	a_flag: assert property (p_flag)
		else $error("Locked flag differs from state");
	property p_ppm_loss;
		(!ppm_in_range_in && !force_lock_data_in) [*3] |=> !lock_state_out;
	endproperty
	a_ppm_loss: assert property (p_ppm_loss)
		else $error("Still data tracking outside ppm range");
	property p_gain;
		(ppm_in_range_in && phase_ok_in && signal_detect_in &&
			!force_lock_ref_in) [*3] |=> lock_state_out;
	endproperty
	a_gain: assert property (p_gain)
		else $error("No data tracking with good detectors");
	property p_rise_cause;
		$rose(lock_state_out) |-> $past(ppm_in_range_in && phase_ok_in, 3) ||
			$past(force_lock_data_in, 3);
	endproperty
	a_rise_cause: assert property (p_rise_cause)
		else $error("Data tracking entered without cause");
	property p_fall_cause;
		$fell(lock_state_out) |-> $past(!ppm_in_range_in ||
			!signal_detect_in || force_lock_ref_in, 3);
	endproperty
	a_fall_cause: assert property (p_fall_cause)
		else $error("Data tracking left without cause");
	property p_word_gap;
		rx_word_valid_out |=> !rx_word_valid_out [*7];
	endproperty
	a_word_gap: assert property (p_word_gap)
		else $error("Words closer than eight bits");
	property p_no_word_ref;
		!lock_state_out [*3] |-> !rx_word_valid_out;
	endproperty
	a_no_word_ref: assert property (p_no_word_ref)
		else $error("Word delivered in reference tracking");
	c_lock: cover property ($rose(lock_state_out));
	c_unlock: cover property ($fell(lock_state_out));
	c_word: cover property (rx_word_valid_out);
endmodule // cdr_lock_ctrl_checker
bind cdr_lock_ctrl cdr_lock_ctrl_checker #(.REC_DIV(REC_DIV)) chk_u (
	.ref_clk_in, .reset_n_in, .ppm_in_range_in, .phase_ok_in,
	.signal_detect_in, .force_lock_ref_in, .force_lock_data_in,
	.freq_locked_out, .lock_state_out, .rx_word_valid_out);

// ==== testbench/testbench.sv ====
// Self-checking bench for the lock controller and deserializer
`timescale 1ns/100ps
`include "cdr_consts.vh"
module testbench;
	logic ref_clk_in = 1'b0, reset_n_in = 1'b0;
	logic ppm_in_range_in = 1'b0, phase_ok_in = 1'b0, signal_detect_in = 1'b0;
	logic force_lock_ref_in = 1'b0, force_lock_data_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, rx_bit_rise_in, rx_bit_fall_in;
	wire freq_locked_out, lock_state_out, rx_word_valid_out, irq_out;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [9:0] rx_word_out;
	logic [9:0] tx_word = 10'h001;
	logic tx_wide = 1'b0;
	logic [1:0] resp;
	logic [31:0] rdv;
	int mismatches = 0, compares = 0;
	// ctrl, ppm, phase, sigdet, force ref, force data, expected state
	logic [8:0] rows [0:10] = '{9'h039, 9'h031, 9'h0a0, 9'h0b9, 9'h018,
		9'h028, 9'h00a, 9'h04b, 9'h04f, 9'h07c, 9'h079};
	cdr_lock_ctrl dut_u (.ref_clk_in, .reset_n_in, .ppm_in_range_in,
		.phase_ok_in, .signal_detect_in, .force_lock_ref_in,
		.force_lock_data_in, .rx_bit_rise_in, .rx_bit_fall_in,
		.freq_locked_out, .lock_state_out, .rx_word_out, .rx_word_valid_out,
		.irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	cdr_tx_model tx_u (.ref_clk_in, .reset_n_in, .word_in(tx_word),
		.wide_in(tx_wide), .bit_rise_out(rx_bit_rise_in),
		.bit_fall_out(rx_bit_fall_in));
	always #12.5 ref_clk_in = ~ref_clk_in;
	task automatic chk(input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
		@(posedge ref_clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
		@(posedge ref_clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Word phase is free, so any even rotation of a lone one is good
	task automatic words(input int pairs);
		logic hit;
		repeat (3) begin
			do @(posedge ref_clk_in); while (!rx_word_valid_out);
			hit = 1'b0;
			for (int i = 0; i < pairs; i++)
				hit = hit | (rx_word_out === (10'h001 << 2*i));
			chk(hit, 1);
		end
	endtask
	initial begin
		repeat (10) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		chk(freq_locked_out, 0);
		rd(`CDR_OFS_CTRL, rdv, resp);
		chk(rdv, `CDR_CTRL_RESET);
		rd(8'h14, rdv, resp);
		chk(resp, `CDR_RESP_SLVERR);
		chk(rdv, 32'h0);
		wr(8'h14, 32'hffffffff, resp);
		chk(resp, `CDR_RESP_SLVERR);
		foreach (rows[i]) begin
			wr(`CDR_OFS_CTRL, {29'h0, rows[i][8:6]}, resp);
			chk(resp, `CDR_RESP_OKAY);
			@(posedge ref_clk_in);
			{ppm_in_range_in, phase_ok_in, signal_detect_in,
				force_lock_ref_in, force_lock_data_in} <= rows[i][5:1];
			repeat (6) @(posedge ref_clk_in);
			chk(lock_state_out, rows[i][0]);
			chk(freq_locked_out, rows[i][0]);
		end
		rd(`CDR_OFS_STATUS, rdv, resp);
		chk(rdv, 32'hf);
		wr(`CDR_OFS_INT_MASK, 32'h1, resp);
		chk(irq_out, 1);
		wr(`CDR_OFS_INT_STAT, 32'h7, resp);
		chk(irq_out, 0);
		words(4);
		ppm_in_range_in <= 1'b0;
		tx_wide <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		wr(`CDR_OFS_CTRL, 32'h5, resp);
		ppm_in_range_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		chk(irq_out, 1);
		words(5);
		wr(`CDR_OFS_INT_MASK, 32'h0, resp);
		chk(irq_out, 0);
		// Reset while locked, ppm detector dropped so no relock follows
		ppm_in_range_in <= 1'b0;
		reset_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		chk(lock_state_out, 0);
		chk(freq_locked_out, 0);
		reset_n_in <= 1'b1;
		rd(`CDR_OFS_CTRL, rdv, resp);
		chk(rdv, `CDR_CTRL_RESET);
		chk(lock_state_out, 0);
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		mismatches++;
		print_verdict;
	end
endmodule // testbench
